// ===== include/tws_pkg.sv
`default_nettype none
package tws_pkg;
    localparam logic [7:0] TWS_WR_ADDR = 8'h8e;
    localparam logic [7:0] TWS_RD_ADDR = 8'h8f;
    localparam logic [3:0] TWS_BYTE_BITS = 4'h8;
    localparam logic [3:0] TWS_FIRST_BIT = 4'h1;
    localparam logic [7:0] TWS_ADDR_STEP = 8'h01;
    localparam logic [7:0] TWS_ADDR_RESET = 8'h00;
    localparam logic [7:0] TWS_REG_RESET = 8'h00;
    localparam int TWS_REG_COUNT = 256;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } tws_state_type;

    typedef enum logic [1:0] {
        KIND_DEV,
        KIND_WA,
        KIND_DATA
    } tws_kind_type;
endpackage
`default_nettype wire

// ===== hdl/tws_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tws_slave (
    input wire logic clk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [7:0] cfg_addr,
    output logic [7:0] cfg_data
);
    // Link domain: reset brought over as a level
    logic lrst_m_r;
    logic lrst_r;
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_done;

    tws_pkg::tws_state_type st_r;
    tws_pkg::tws_kind_type kind_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic rw_r;
    logic more_r;
    logic inc_pend_r;
    logic sda_oe_r;
    logic sda_out_r;
    logic [7:0] addr_r;
    logic [7:0] rd_hold_r;

    logic req_tgl_r;
    logic req_we_r;
    logic [7:0] req_addr_r;
    logic [7:0] req_wdata_r;
    logic [1:0] rsp_sync_r;
    logic rsp_seen_r;

    // Core domain
    logic [1:0] req_sync_r;
    logic req_seen_r;
    logic rsp_tgl_r;
    logic [7:0] rsp_data_r;
    logic [7:0] cfg_data_r;
    logic [7:0] mem [0:tws_pkg::TWS_REG_COUNT-1];
    logic req_new;

    always_ff @(posedge link_clk) begin
        lrst_m_r <= reset;
        lrst_r <= lrst_m_r;
    end

    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end

    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    // Data moving while clock stays high marks start or stop
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign byte_done = (st_r == tws_pkg::ST_RX) && scl_fall && (cnt_r == tws_pkg::TWS_BYTE_BITS);

    // Bit and byte engine
    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            st_r <= tws_pkg::ST_IDLE;
            kind_r <= tws_pkg::KIND_DEV;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            more_r <= 1'b0;
            inc_pend_r <= 1'b0;
            sda_oe_r <= 1'b0;
            sda_out_r <= 1'b0;
        end else if (start_det) begin
            st_r <= tws_pkg::ST_RX;
            kind_r <= tws_pkg::KIND_DEV;
            cnt_r <= 4'h0;
            inc_pend_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (stop_det) begin
            st_r <= tws_pkg::ST_IDLE;
            inc_pend_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            case (st_r)
                tws_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (byte_done) begin
                        cnt_r <= 4'h0;
                        case (kind_r)
                            tws_pkg::KIND_DEV: begin
                                if (shift_r == tws_pkg::TWS_WR_ADDR) begin
                                    sda_oe_r <= 1'b1;
                                    rw_r <= 1'b0;
                                    kind_r <= tws_pkg::KIND_WA;
                                    st_r <= tws_pkg::ST_RX_ACK;
                                end else if (shift_r == tws_pkg::TWS_RD_ADDR) begin
                                    sda_oe_r <= 1'b1;
                                    rw_r <= 1'b1;
                                    st_r <= tws_pkg::ST_RX_ACK;
                                end else begin
                                    st_r <= tws_pkg::ST_IDLE;
                                end
                            end
                            tws_pkg::KIND_WA: begin
                                sda_oe_r <= 1'b1;
                                kind_r <= tws_pkg::KIND_DATA;
                                st_r <= tws_pkg::ST_RX_ACK;
                            end
                            default: begin
                                sda_oe_r <= 1'b1;
                                inc_pend_r <= 1'b1;
                                st_r <= tws_pkg::ST_RX_ACK;
                            end
                        endcase
                    end
                end
                tws_pkg::ST_RX_ACK: begin
                    if (scl_rise) begin
                        inc_pend_r <= 1'b0;
                    end else if (scl_fall) begin
                        if (rw_r) begin
                            // No command byte needed before data
                            st_r <= tws_pkg::ST_TX;
                            shift_r <= rd_hold_r;
                            sda_oe_r <= ~rd_hold_r[7];
                            cnt_r <= tws_pkg::TWS_FIRST_BIT;
                        end else begin
                            st_r <= tws_pkg::ST_RX;
                            sda_oe_r <= 1'b0;
                        end
                    end
                end
                tws_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_r == tws_pkg::TWS_BYTE_BITS) begin
                            sda_oe_r <= 1'b0;
                            st_r <= tws_pkg::ST_TX_ACK;
                        end else begin
                            sda_oe_r <= ~shift_r[6];
                            shift_r <= {shift_r[6:0], 1'b0};
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                end
                tws_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        more_r <= ~sda_s;
                    end else if (scl_fall) begin
                        if (more_r) begin
                            st_r <= tws_pkg::ST_TX;
                            shift_r <= rd_hold_r;
                            sda_oe_r <= ~rd_hold_r[7];
                            cnt_r <= tws_pkg::TWS_FIRST_BIT;
                        end else begin
                            // Line stays released until stop or start
                            st_r <= tws_pkg::ST_IDLE;
                        end
                    end
                end
                tws_pkg::ST_IDLE: begin
                    sda_oe_r <= 1'b0;
                end
                default: begin
                    st_r <= tws_pkg::ST_IDLE;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // Word address counter survives stop and start
    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            addr_r <= tws_pkg::TWS_ADDR_RESET;
        end else if (byte_done && kind_r == tws_pkg::KIND_WA) begin
            addr_r <= shift_r;
        end else if (st_r == tws_pkg::ST_RX_ACK && scl_rise && inc_pend_r) begin
            addr_r <= addr_r + tws_pkg::TWS_ADDR_STEP;
        end else if (st_r == tws_pkg::ST_TX_ACK && scl_rise) begin
            addr_r <= addr_r + tws_pkg::TWS_ADDR_STEP;
        end
    end

    // Requests held stable until the next toggle; bytes are microseconds apart
    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            req_tgl_r <= 1'b0;
            req_we_r <= 1'b0;
            req_addr_r <= 8'h00;
            req_wdata_r <= 8'h00;
        end else if (byte_done && kind_r == tws_pkg::KIND_DATA) begin
            req_tgl_r <= ~req_tgl_r;
            req_we_r <= 1'b1;
            req_addr_r <= addr_r;
            req_wdata_r <= shift_r;
        end else if (byte_done && kind_r == tws_pkg::KIND_DEV && shift_r == tws_pkg::TWS_RD_ADDR) begin
            req_tgl_r <= ~req_tgl_r;
            req_we_r <= 1'b0;
            req_addr_r <= addr_r;
        end else if (st_r == tws_pkg::ST_TX_ACK && scl_rise && !sda_s) begin
            // Prefetch next byte; half a clock period covers the crossing
            req_tgl_r <= ~req_tgl_r;
            req_we_r <= 1'b0;
            req_addr_r <= addr_r + tws_pkg::TWS_ADDR_STEP;
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            rsp_sync_r <= 2'h0;
            rsp_seen_r <= 1'b0;
            rd_hold_r <= 8'h00;
        end else begin
            rsp_sync_r <= {rsp_sync_r[0], rsp_tgl_r};
            if (rsp_sync_r[1] != rsp_seen_r) begin
                rsp_seen_r <= rsp_sync_r[1];
                rd_hold_r <= rsp_data_r;
            end
        end
    end

    assign sda_oe = sda_oe_r;
    assign sda_out = sda_out_r;

    // Register array on the core clock
    assign req_new = req_sync_r[1] != req_seen_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            req_sync_r <= 2'h0;
            req_seen_r <= 1'b0;
            rsp_tgl_r <= 1'b0;
            rsp_data_r <= 8'h00;
        end else begin
            req_sync_r <= {req_sync_r[0], req_tgl_r};
            if (req_new) begin
                req_seen_r <= req_sync_r[1];
                if (!req_we_r) begin
                    rsp_data_r <= mem[req_addr_r];
                    rsp_tgl_r <= ~rsp_tgl_r;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < tws_pkg::TWS_REG_COUNT; i++) begin
                mem[i] <= tws_pkg::TWS_REG_RESET;
            end
        end else if (req_new && req_we_r) begin
            mem[req_addr_r] <= req_wdata_r;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_data_r <= tws_pkg::TWS_REG_RESET;
        end else begin
            cfg_data_r <= mem[cfg_addr];
        end
    end

    assign cfg_data = cfg_data_r;

    wr_addr_ack_a: assert property (@(posedge link_clk) disable iff (lrst_r)
        byte_done && kind_r == tws_pkg::KIND_DEV && shift_r == tws_pkg::TWS_WR_ADDR
        |=> sda_oe_r && st_r == tws_pkg::ST_RX_ACK && !rw_r)
        else $error("write address not acknowledged");

    rd_addr_ack_a: assert property (@(posedge link_clk) disable iff (lrst_r)
        byte_done && kind_r == tws_pkg::KIND_DEV && shift_r == tws_pkg::TWS_RD_ADDR
        |=> sda_oe_r && rw_r)
        else $error("read address not acknowledged");

    foreign_silent_a: assert property (@(posedge link_clk) disable iff (lrst_r)
        byte_done && kind_r == tws_pkg::KIND_DEV && shift_r != tws_pkg::TWS_WR_ADDR
        && shift_r != tws_pkg::TWS_RD_ADDR |=> !sda_oe_r && st_r == tws_pkg::ST_IDLE)
        else $error("answered a foreign address");

    word_addr_load_a: assert property (@(posedge link_clk) disable iff (lrst_r)
        byte_done && kind_r == tws_pkg::KIND_WA |=> addr_r == $past(shift_r) && kind_r == tws_pkg::KIND_DATA)
        else $error("word address not loaded");

    write_inc_a: assert property (@(posedge link_clk) disable iff (lrst_r)
        st_r == tws_pkg::ST_RX_ACK && scl_rise && inc_pend_r && !start_det && !stop_det
        |=> addr_r == $past(addr_r) + tws_pkg::TWS_ADDR_STEP)
        else $error("counter did not advance in acknowledge");

    tx_first_a: assert property (@(posedge link_clk) disable iff (lrst_r)
        st_r == tws_pkg::ST_RX_ACK && rw_r && scl_fall
        |=> st_r == tws_pkg::ST_TX && sda_oe_r == !$past(rd_hold_r[7]))
        else $error("first read byte not driven");

    ack_released_a: assert property (@(posedge link_clk) disable iff (lrst_r)
        st_r == tws_pkg::ST_TX_ACK |-> !sda_oe_r)
        else $error("data line held during master acknowledge");

    nack_idle_a: assert property (@(posedge link_clk) disable iff (lrst_r)
        st_r == tws_pkg::ST_TX_ACK && scl_fall && !more_r
        |=> st_r == tws_pkg::ST_IDLE && !sda_oe_r)
        else $error("transmit continued after not-acknowledge");

    stop_keeps_a: assert property (@(posedge link_clk) disable iff (lrst_r)
        stop_det |=> st_r == tws_pkg::ST_IDLE && addr_r == $past(addr_r))
        else $error("stop lost counter or state");

    core_write_a: assert property (@(posedge clk) disable iff (reset)
        req_new && req_we_r |=> mem[$past(req_addr_r)] == $past(req_wdata_r))
        else $error("register write not stored");
endmodule
`default_nettype wire

// ===== sim/tws_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda_wire
);
    // Both clock phases stay above the 500 ns minimum
    localparam int HALF = 600;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Serves as start from idle and as repeated start from clock low
    task automatic start_cond();
        sda_low = 1'b0;
        #(HALF / 2);
        scl = 1'b1;
        #(HALF / 2);
        sda_low = 1'b1;
        #(HALF / 2);
        scl = 1'b0;
        #(HALF / 2);
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        #(HALF / 2);
        scl = 1'b1;
        #(HALF / 2);
        sda_low = 1'b0;
        #HALF;
    endtask

    task automatic bit_out(input logic b);
        sda_low = ~b;
        #(HALF / 2);
        scl = 1'b1;
        #HALF;
        scl = 1'b0;
        #(HALF / 2);
    endtask

    // Released line floats to the pull-up, so a silent slave reads as 1
    task automatic bit_in(output logic b);
        sda_low = 1'b0;
        #(HALF / 2);
        scl = 1'b1;
        #(HALF / 2);
        b = sda_wire;
        #(HALF / 2);
        scl = 1'b0;
        #(HALF / 2);
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(b);
        ack = ~b;
    endtask

    task automatic read_byte(input logic give_ack, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_in(b);
            d[i] = b;
        end
        bit_out(~give_ack);
    endtask
endmodule
`default_nettype wire

// ===== sim/test_two_wire_register_slave.sv
`timescale 1ns/1ps
`default_nettype none
module test_two_wire_register_slave;
    logic clk, link_clk, reset, scl, sda_low, sda_oe, sda_out, sda_wire;
    logic [7:0] cfg_addr, cfg_data, a;
    logic [7:0] mem [256];
    int ptr, n_mismatch, check_count;

    assign sda_wire = ~(sda_low | sda_oe);

    tws_slave i_dut (.clk(clk), .reset(reset), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .cfg_addr(cfg_addr), .cfg_data(cfg_data));
    tws_master_model i_master (.scl(scl), .sda_low(sda_low), .sda_wire(sda_wire));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        link_clk = 1'b0;
        #3.7;
        forever #6 link_clk = ~link_clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic ack;
        i_master.write_byte(d, ack);
        check("ack", {7'h00, ack}, {7'h00, exp_ack});
    endtask

    task automatic scan();
        for (int i = 0; i < 256; i++) begin
            @(negedge clk) cfg_addr = 8'(i);
            @(negedge clk);
            check("cfg_data", cfg_data, mem[i]);
        end
        check("sda_out", {7'h00, sda_out}, 8'h00);
    endtask

    task automatic write_seq(input logic [7:0] wa, input int n);
        logic [7:0] d;
        i_master.start_cond();
        send(tws_pkg::TWS_WR_ADDR, 1'b1);
        send(wa, 1'b1);
        ptr = wa;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            send(d, 1'b1);
            mem[ptr] = d;
            ptr = (ptr + 1) % 256;
        end
        i_master.stop_cond();
    endtask

    task automatic read_seq(input int n, input logic set_wa, input logic [7:0] wa);
        logic [7:0] d;
        i_master.start_cond();
        if (set_wa) begin
            send(tws_pkg::TWS_WR_ADDR, 1'b1);
            send(wa, 1'b1);
            ptr = wa;
            i_master.start_cond();
        end
        send(tws_pkg::TWS_RD_ADDR, 1'b1);
        for (int i = 0; i < n; i++) begin
            i_master.read_byte(i < n - 1, d);
            check("read data", d, mem[ptr]);
            ptr = (ptr + 1) % 256;
        end
        check("release", {7'h00, sda_oe}, 8'h00);
        i_master.stop_cond();
    endtask

    initial begin
        #800_000;
        n_mismatch++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        test_done();
    end

    initial begin
        void'($urandom(32'h754d5fe3));
        reset = 1'b1;
        cfg_addr = 8'h00;
        n_mismatch = 0;
        check_count = 0;
        ptr = 0;
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        repeat (10) @(negedge clk);
        scan();
        $display("Test reset contents done");
        // Crosses FF to 00 to catch a counter that saturates
        write_seq(8'hfd, 6);
        write_seq(8'($urandom), 3);
        scan();
        $display("Test page write done");
        read_seq(6, 1'b1, 8'hfb);
        $display("Test random and sequential read done");
        read_seq(3, 1'b0, 8'h00);
        read_seq(1, 1'b0, 8'h00);
        $display("Test current address read done");
        for (int i = 0; i < 3; i++) begin
            a = 8'($urandom);
            if (a[7:1] == tws_pkg::TWS_WR_ADDR[7:1]) begin
                a = a ^ 8'h10;
            end
            i_master.start_cond();
            send(a, 1'b0);
            send(8'($urandom), 1'b0);
            i_master.stop_cond();
        end
        read_seq(1, 1'b0, 8'h00);
        $display("Test foreign address done");
        a = 8'($urandom);
        i_master.start_cond();
        send(tws_pkg::TWS_WR_ADDR, 1'b1);
        send(a, 1'b1);
        ptr = a;
        for (int i = 0; i < 4; i++) begin
            i_master.bit_out(1'($urandom));
        end
        // Start arriving mid-byte must drop the byte but keep the counter
        read_seq(2, 1'b0, 8'h00);
        scan();
        $display("Test mid-byte start done");
        test_done();
    end
endmodule
`default_nettype wire
